// ### src/bkrc_pkg.sv
package bkrc_pkg;
  // register offsets on the serial control port
  localparam logic [7:0] BKRC_OFS_R0_LIMIT_SLEW = 8'h03;
  localparam logic [7:0] BKRC_OFS_R1_MODE_ENABLE = 8'h04;
  localparam logic [7:0] BKRC_OFS_R1_LIMIT_SLEW = 8'h05;
  localparam logic [7:0] BKRC_OFS_R0_VOLTAGE_CODE = 8'h06;
  localparam logic [7:0] BKRC_OFS_FIRST = 8'h03;
  localparam int BKRC_NUM_REGS = 4;
  // reset values
  localparam logic [7:0] BKRC_RST_LIMIT_SLEW = 8'h1C;
  localparam logic [7:0] BKRC_RST_MODE_ENABLE = 8'h0F;
  localparam logic [7:0] BKRC_RST_VOLTAGE_CODE = 8'hFF;
  // field positions
  localparam int BKRC_LIM_LSB = 3;
  localparam int BKRC_SLEW_LSB = 0;
  localparam int BKRC_FPW_BIT = 3;
  localparam int BKRC_DIS_BIT = 2;
  localparam int BKRC_PIN_BIT = 1;
  localparam int BKRC_EN_BIT = 0;
  localparam logic [7:0] BKRC_LS_MASK = 8'h3F;
  localparam logic [7:0] BKRC_ME_MASK = 8'h0F;
  localparam logic [7:0] BKRC_ZERO = 8'h00;
  // current limit in 100 mA units
  localparam logic [5:0] BKRC_ILIM_BASE = 6'h0F;
  localparam logic [5:0] BKRC_ILIM_STEP = 6'h05;
  // voltage segments, millivolts
  localparam logic [7:0] BKRC_SEG1_CODE = 8'h14;
  localparam logic [7:0] BKRC_SEG2_CODE = 8'h18;
  localparam logic [7:0] BKRC_SEG3_CODE = 8'h9E;
  localparam logic [11:0] BKRC_SEG1_MV = 12'h2BC;
  localparam logic [11:0] BKRC_SEG2_MV = 12'h2DF;
  localparam logic [11:0] BKRC_SEG3_MV = 12'h58C;
  localparam logic [11:0] BKRC_SEG1_STEP = 12'h00A;
  localparam logic [11:0] BKRC_SEG2_STEP = 12'h005;
  localparam logic [11:0] BKRC_SEG3_STEP = 12'h014;
endpackage : bkrc_pkg

// ### src/bkrc_regfile.sv
`timescale 1ns/1ps
// small register memory: four bytes, registered read data
module bkrc_regfile
  import bkrc_pkg::*;
#(
  parameter int DEPTH = BKRC_NUM_REGS
)(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_we,
  input wire logic [1:0] i_idx,
  input wire logic [7:0] i_wdata,
  input wire logic [1:0] i_ridx,
  output logic [7:0] o_rdata,
  output logic [8*DEPTH-1:0] o_all
);
  logic [7:0] mem_ff [DEPTH];

  // each byte resets to its own default and drops writes to reserved bits
  for (genvar g = 0; g < DEPTH; g++)
  begin : g_byte
    localparam logic [7:0] RST = (g == 1) ? BKRC_RST_MODE_ENABLE :
                                 (g == 3) ? BKRC_RST_VOLTAGE_CODE : BKRC_RST_LIMIT_SLEW;
    localparam logic [7:0] MSK = (g == 1) ? BKRC_ME_MASK :
                                 (g == 3) ? 8'hFF : BKRC_LS_MASK;
    always_ff @(posedge i_clk or posedge i_rst)
    begin
      if (i_rst)
      begin
        mem_ff[g] <= RST;
      end
      else if (i_we && (i_idx == 2'(g)))
      begin
        mem_ff[g] <= i_wdata & MSK;
      end
    end
    assign o_all[8*g +: 8] = mem_ff[g];
  end

  // read data comes out of a register
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rdata <= BKRC_ZERO;
    end
    else
    begin
      o_rdata <= mem_ff[i_ridx];
    end
  end
endmodule : bkrc_regfile

// ### src/bkrc_top.sv
`timescale 1ns/1ps
// Functional notes
// R01: the four registers sit at byte offsets 0x03, 0x04, 0x05 and 0x06.
// R02: current-limit codes 0..3 select 1.5, 2.0, 2.5 and 3.0 A.
// R03: a new current-limit code applies at once, even with the regulator running.
// R04: the host never writes current-limit codes 4 to 7.
// R05: slew codes 2..7 select 10, 7.5, 3.8, 1.9, 0.94 and 0.47 mV/us.
// R06: the selected slew rate applies to rising and falling output changes alike.
// R07: the host never writes slew codes 0 or 1.
// R08: the regulator-1 mode bit clear means automatic mode, set means forced pulse width.
// R09: with discharge enabled, the discharge resistor connects while regulator 1 is off; in reset the code holds o_REG1_DISCHARGE low.
// R10: pin gating 0 lets the enable bit alone run regulator 1, 1 needs the enable pin too.
// R11: enable bit 0 disables regulator 1 and 1 enables it, subject to pin gating.
// R12: the host writes regulator-0 voltage codes from 0x14 upward only.
// R13: codes 0x14..0x17 give 0.70..0.73 V in 10 mV steps.
// R14: codes 0x18..0x9D give 0.735..1.4 V in 5 mV steps.
// R15: codes 0x9E..0xFF give 1.42..3.36 V in 20 mV steps.
// R16: the host updates single fields by read-modify-write.
module bkrc_top
  import bkrc_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic i_WR,
  input wire logic i_RD,
  input wire logic [7:0] i_ADDR,
  input wire logic [7:0] i_WDATA,
  input wire logic i_EN_PIN,
  output logic [7:0] o_RDATA,
  output logic o_RVALID,
  output logic [2:0] o_REG0_CURRENT_LIMIT,
  output logic [2:0] o_REG0_RAMP_RATE,
  output logic [5:0] o_REG0_ILIM_DA,
  output logic [11:0] o_REG0_VOUT_MV,
  output logic [2:0] o_REG1_CURRENT_LIMIT,
  output logic [2:0] o_REG1_RAMP_RATE,
  output logic [5:0] o_REG1_ILIM_DA,
  output logic o_REG1_FORCED_PULSE_WIDTH,
  output logic o_REG1_RUN,
  output logic o_REG1_DISCHARGE
);
  //////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // offset in the bank, used for both write and read
  function automatic logic in_bank(input logic [7:0] a);
    in_bank = (a >= BKRC_OFS_R0_LIMIT_SLEW) && (a <= BKRC_OFS_R0_VOLTAGE_CODE);
  endfunction : in_bank

  // switch current limit in 100 mA units; reserved codes hold 3.0 A
  function automatic logic [5:0] ilim_da(input logic [2:0] c);
    logic [2:0] k;
    k = (c > 3'h3) ? 3'h3 : c;
    ilim_da = BKRC_ILIM_BASE + 6'(BKRC_ILIM_STEP * 6'(k));
  endfunction : ilim_da

  // piecewise linear voltage code to millivolts
  function automatic logic [11:0] code_mv(input logic [7:0] c);
    logic [11:0] d;
    d = 12'h000;
    if (c >= BKRC_SEG3_CODE)
    begin
      d = 12'(c - BKRC_SEG3_CODE);
      code_mv = BKRC_SEG3_MV + 12'(d * BKRC_SEG3_STEP); // [R15]
    end
    else if (c >= BKRC_SEG2_CODE)
    begin
      d = 12'(c - BKRC_SEG2_CODE);
      code_mv = BKRC_SEG2_MV + 12'(d * BKRC_SEG2_STEP); // [R14]
    end
    else if (c >= BKRC_SEG1_CODE)
    begin
      d = 12'(c - BKRC_SEG1_CODE);
      code_mv = BKRC_SEG1_MV + 12'(d * BKRC_SEG1_STEP); // [R13]
    end
    else
    begin
      code_mv = BKRC_SEG1_MV; // reserved codes: hold the lowest level
    end
  endfunction : code_mv

  //////////////////////////////////////////////////////////////////////////////
  // register bank

  logic wr_hit;
  logic [1:0] wr_idx;
  logic [1:0] rd_idx;
  logic [7:0] mem_rdata;
  logic [31:0] regs;
  logic rd_hit_ff;
  logic rd_pend_ff;

  // address decode: bank index is offset minus the first offset
  always_comb
  begin
    wr_hit = 1'b0;
    if (i_WR && in_bank(i_ADDR))
    begin
      wr_hit = 1'b1; // [R01]
    end
  end
  assign wr_idx = 2'(i_ADDR - BKRC_OFS_FIRST);
  assign rd_idx = 2'(i_ADDR - BKRC_OFS_FIRST);

  bkrc_regfile #(
    .DEPTH(BKRC_NUM_REGS)
  ) u_regs (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_we(wr_hit),
    .i_idx(wr_idx),
    .i_wdata(i_WDATA),
    .i_ridx(rd_idx),
    .o_rdata(mem_rdata),
    .o_all(regs)
  );

  // read pipeline: memory answers one cycle later, output flop one more
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      rd_pend_ff <= 1'b0;
    end
    else
    begin
      rd_pend_ff <= i_RD;
    end
  end

  // hit flag travels with the read so that unmapped offsets answer zero
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      rd_hit_ff <= 1'b0;
    end
    else
    begin
      rd_hit_ff <= in_bank(i_ADDR); // [R01]
    end
  end

  // unmapped offsets read as zero
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      o_RDATA <= BKRC_ZERO;
      o_RVALID <= 1'b0;
    end
    else
    begin
      o_RVALID <= rd_pend_ff;
      o_RDATA <= (rd_pend_ff && rd_hit_ff) ? mem_rdata : BKRC_ZERO;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // regulator controls

  logic [7:0] r0_ls;
  logic [7:0] r1_me;
  logic [7:0] r1_ls;
  logic [7:0] r0_vc;
  assign r0_ls = regs[7:0];
  assign r1_me = regs[15:8];
  assign r1_ls = regs[23:16];
  assign r0_vc = regs[31:24];

  // reset levels of the derived outputs, fixed at elaboration so reset loads plain constants
  localparam logic [2:0] RST_LIMIT = BKRC_RST_LIMIT_SLEW[BKRC_LIM_LSB +: 3];
  localparam logic [2:0] RST_RAMP = BKRC_RST_LIMIT_SLEW[BKRC_SLEW_LSB +: 3];
  localparam logic [5:0] RST_ILIM_DA = ilim_da(RST_LIMIT);
  localparam logic [11:0] RST_VOUT_MV = code_mv(BKRC_RST_VOLTAGE_CODE);

  // reg0 limit code follows the register live, no disable needed first
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      o_REG0_CURRENT_LIMIT <= RST_LIMIT;
    end
    else
    begin
      o_REG0_CURRENT_LIMIT <= r0_ls[BKRC_LIM_LSB +: 3]; // [R03]
    end
  end

  // reg1 limit code, likewise applied while the regulator runs
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      o_REG1_CURRENT_LIMIT <= RST_LIMIT;
    end
    else
    begin
      o_REG1_CURRENT_LIMIT <= r1_ls[BKRC_LIM_LSB +: 3]; // [R03]
    end
  end

  // reg0 limit current; a reserved code would hold the top step, not wrap
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      o_REG0_ILIM_DA <= RST_ILIM_DA;
    end
    else
    begin
      o_REG0_ILIM_DA <= ilim_da(r0_ls[BKRC_LIM_LSB +: 3]); // [R02]
    end
  end

  // reg1 limit current
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      o_REG1_ILIM_DA <= RST_ILIM_DA;
    end
    else
    begin
      o_REG1_ILIM_DA <= ilim_da(r1_ls[BKRC_LIM_LSB +: 3]); // [R02]
    end
  end

  // one ramp code drives both ramp directions in the analog slew stage
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      o_REG0_RAMP_RATE <= RST_RAMP;
    end
    else
    begin
      o_REG0_RAMP_RATE <= r0_ls[BKRC_SLEW_LSB +: 3]; // [R05] [R06]
    end
  end

  // reg1 ramp code, same single code for rising and falling edges
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      o_REG1_RAMP_RATE <= RST_RAMP;
    end
    else
    begin
      o_REG1_RAMP_RATE <= r1_ls[BKRC_SLEW_LSB +: 3]; // [R05] [R06]
    end
  end

  // target voltage in millivolts
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      o_REG0_VOUT_MV <= RST_VOUT_MV;
    end
    else
    begin
      o_REG0_VOUT_MV <= code_mv(r0_vc);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // regulator-1 run, mode and discharge
  logic run1;
  assign run1 = r1_me[BKRC_EN_BIT] && (!r1_me[BKRC_PIN_BIT] || i_EN_PIN); // [R10] [R11]

  // mode bit passes straight through to the switching stage
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      o_REG1_FORCED_PULSE_WIDTH <= BKRC_RST_MODE_ENABLE[BKRC_FPW_BIT];
    end
    else
    begin
      o_REG1_FORCED_PULSE_WIDTH <= r1_me[BKRC_FPW_BIT]; // [R08]
    end
  end

  // run stays off in reset; the pin is seen one edge later than its change
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      o_REG1_RUN <= 1'b0;
    end
    else
    begin
      o_REG1_RUN <= run1; // [R10] [R11]
    end
  end

  // outside reset, discharge is the complement of run, gated by its enable bit
  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      o_REG1_DISCHARGE <= 1'b0;
    end
    else
    begin
      o_REG1_DISCHARGE <= r1_me[BKRC_DIS_BIT] && !run1; // [R09]
    end
  end
endmodule : bkrc_top

// ### bench/bkrc_chk.sv
`timescale 1ns/1ps
// watches the port side of the control bank; outputs tie to the write that caused them
module bkrc_chk
  import bkrc_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic i_WR,
  input wire logic i_RD,
  input wire logic [7:0] i_ADDR,
  input wire logic [7:0] i_WDATA,
  input wire logic i_EN_PIN,
  input wire logic [7:0] o_RDATA,
  input wire logic o_RVALID,
  input wire logic [2:0] o_REG0_CURRENT_LIMIT,
  input wire logic [2:0] o_REG0_RAMP_RATE,
  input wire logic [5:0] o_REG0_ILIM_DA,
  input wire logic [11:0] o_REG0_VOUT_MV,
  input wire logic [2:0] o_REG1_CURRENT_LIMIT,
  input wire logic [2:0] o_REG1_RAMP_RATE,
  input wire logic [5:0] o_REG1_ILIM_DA,
  input wire logic o_REG1_FORCED_PULSE_WIDTH,
  input wire logic o_REG1_RUN,
  input wire logic o_REG1_DISCHARGE
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  // reserved limit codes saturate at the top step
  function automatic logic [5:0] ilim(input logic [2:0] c);
    return c[2] ? 6'h1E : 6'h0F + 6'h05 * c;
  endfunction : ilim
  function automatic logic [11:0] mv(input logic [7:0] c);
    if (c < 8'h18) return 12'h2BC + 12'h00A * (c - 8'h14);
    if (c < 8'h9E) return 12'h2DF + 12'h005 * (c - 8'h18);
    return 12'h58C + 12'h014 * (c - 8'h9E);
  endfunction : mv
  sequence s_wr(a);
    i_WR && i_ADDR == a;
  endsequence
  property p_ilim0;
    o_REG0_ILIM_DA == ilim(o_REG0_CURRENT_LIMIT);
  endproperty
  property p_ilim1;
    o_REG1_ILIM_DA == ilim(o_REG1_CURRENT_LIMIT);
  endproperty
  property p_ls0;
    logic [7:0] d;
    (s_wr(8'h03), d = i_WDATA) |-> ##2 {o_REG0_CURRENT_LIMIT, o_REG0_RAMP_RATE} == d[5:0];
  endproperty
  property p_ls1;
    logic [7:0] d;
    (s_wr(8'h05), d = i_WDATA) |-> ##2 {o_REG1_CURRENT_LIMIT, o_REG1_RAMP_RATE} == d[5:0];
  endproperty
  property p_run;
    logic [7:0] d;
    (s_wr(8'h04), d = i_WDATA) |-> ##2 o_REG1_RUN == (d[0] && (!d[1] || $past(i_EN_PIN)));
  endproperty
  property p_dis;
    logic [7:0] d;
    (s_wr(8'h04), d = i_WDATA) |-> ##2 o_REG1_DISCHARGE == (d[2] && !o_REG1_RUN);
  endproperty
  property p_fpw;
    logic [7:0] d;
    (s_wr(8'h04), d = i_WDATA) |-> ##2 o_REG1_FORCED_PULSE_WIDTH == d[3];
  endproperty
  property p_vout;
    logic [7:0] d;
    (s_wr(8'h06), d = i_WDATA) |-> ##2 o_REG0_VOUT_MV == mv(d);
  endproperty
  property p_unmapped;
    i_RD && (i_ADDR < 8'h03 || i_ADDR > 8'h06) |-> ##2 o_RVALID && o_RDATA == 8'h00;
  endproperty
  a_ilim0: assert property (p_ilim0) else $error("reg0 limit current wrong");
  a_ilim1: assert property (p_ilim1) else $error("reg1 limit current wrong");
  a_ls0: assert property (p_ls0) else $error("reg0 limit or ramp not applied");
  a_ls1: assert property (p_ls1) else $error("reg1 limit or ramp not applied");
  a_run: assert property (p_run) else $error("reg1 run wrong");
  a_dis: assert property (p_dis) else $error("reg1 discharge wrong");
  a_fpw: assert property (p_fpw) else $error("reg1 mode wrong");
  a_vout: assert property (p_vout) else $error("reg0 voltage wrong");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : bkrc_chk
////////////////////
bind bkrc_top bkrc_chk bkrc_chk_inst (.I_CLK, .I_RST, .i_WR, .i_RD, .i_ADDR, .i_WDATA,
  .i_EN_PIN, .o_RDATA, .o_RVALID, .o_REG0_CURRENT_LIMIT, .o_REG0_RAMP_RATE, .o_REG0_ILIM_DA,
  .o_REG0_VOUT_MV, .o_REG1_CURRENT_LIMIT, .o_REG1_RAMP_RATE, .o_REG1_ILIM_DA,
  .o_REG1_FORCED_PULSE_WIDTH,
  .o_REG1_RUN, .o_REG1_DISCHARGE);

// ### bench/bkrc_host.sv
`timescale 1ns/1ps
// host on the control port; callers pass only legal codes
module bkrc_host (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0,
  output logic [7:0] o_addr = 8'h00,
  output logic [7:0] o_wdata = 8'h00
);
  // released data flips so a stale byte is never mistaken for a write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk) #1;
    {o_wr, o_addr, o_wdata} = {1'b1, a, d};
    @(posedge i_clk) #1;
    {o_wr, o_wdata} = {1'b0, ~d};
  endtask : wr
  // answer stands for one cycle, launched by the edge after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk) #1;
    {o_rd, o_addr} = {1'b1, a};
    @(posedge i_clk) #1;
    o_rd = 1'b0;
    @(posedge i_clk);
    #1 d = i_rvalid ? i_rdata : 8'hXX;
  endtask : rd
  // single-field update keeps the other bits
  task automatic rmw(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
    logic [7:0] d;
    rd(a, d);
    wr(a, (d & ~m) | (v & m));
  endtask : rmw
endmodule : bkrc_host

// ### bench/test_bkrc_top.sv
`timescale 1ns/1ps
module test_bkrc_top;
  logic clk = 0, rst = 1, en_pin = 1, wr, rd, rvalid, fpw, run, dis;
  logic [7:0] addr, wdata, rdata, d;
  logic [2:0] lim0, ramp0, lim1, ramp1;
  logic [5:0] ilim0, ilim1;
  logic [11:0] mv0;
  int errors = 0, tests_run = 0;
  always #4 clk = ~clk;
  bkrc_top bkrc_top_inst (.I_CLK(clk), .I_RST(rst), .i_WR(wr), .i_RD(rd), .i_ADDR(addr),
    .i_WDATA(wdata), .i_EN_PIN(en_pin), .o_RDATA(rdata), .o_RVALID(rvalid),
    .o_REG0_CURRENT_LIMIT(lim0), .o_REG0_RAMP_RATE(ramp0), .o_REG0_ILIM_DA(ilim0),
    .o_REG0_VOUT_MV(mv0), .o_REG1_CURRENT_LIMIT(lim1), .o_REG1_RAMP_RATE(ramp1),
    .o_REG1_ILIM_DA(ilim1), .o_REG1_FORCED_PULSE_WIDTH(fpw), .o_REG1_RUN(run),
    .o_REG1_DISCHARGE(dis));
  bkrc_host bkrc_host_inst (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_wr(wr),
    .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
  ////////////////////
  task chk(input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task conclude;
    $display("errors %0d compares %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  // defaults and the unmapped neighbours 0x02 and 0x07
  task automatic t_defaults;
    logic [7:0] exp [8] = '{8'h00, 8'h00, 8'h00, 8'h1C, 8'h0F, 8'h1C, 8'hFF, 8'h00};
    @(posedge clk) #1;
    chk(ilim0, 12'h01E);
    chk({ramp0, lim0, ilim1}, 12'h8DE);
    chk({ramp1, lim1, fpw, run, dis}, 12'h11E);
    chk(mv0, 12'hD20);
    for (int a = 2; a < 8; a++)
    begin
      bkrc_host_inst.rd(a[7:0], d);
      chk(d, exp[a]);
    end
  endtask : t_defaults
  // every legal limit and slew code, changed while the regulator runs
  task t_limits;
    for (int i = 0; i < 6; i++)
    begin
      bkrc_host_inst.wr(8'h03, {2'h0, 3'(i % 4), 3'(i + 2)});
      bkrc_host_inst.wr(8'h05, {2'h3, 3'(i % 4), 3'(i + 2)});
      @(posedge clk) #1;
      chk({lim0, lim1}, {3'(i % 4), 3'(i % 4)});
      chk(ilim0, 12'(15 + 5 * (i % 4)));
      chk({ilim1, ramp0, ramp1}, {6'(15 + 5 * (i % 4)), 3'(i + 2), 3'(i + 2)});
      bkrc_host_inst.rd(8'h05, d);
      chk(d, {2'h0, 3'(i % 4), 3'(i + 2)});
    end
  endtask : t_limits
  // all mode-enable patterns against both pin levels
  task t_reg1;
    logic r;
    for (int v = 0; v < 32; v++)
    begin
      @(posedge clk) #1 en_pin = v[4];
      bkrc_host_inst.wr(8'h04, {4'hF, 4'(v)});
      @(posedge clk) #1 r = v[0] && (!v[1] || v[4]);
      chk({fpw, run, dis}, {v[3], r, v[2] && !r});
      bkrc_host_inst.rd(8'h04, d);
      chk(d, 8'(v % 16));
    end
    bkrc_host_inst.rmw(8'h04, 8'h08, 8'h00);
    @(posedge clk) #1;
    chk({fpw, run, dis}, 3'b010);
  endtask : t_reg1
  // segment edges of the voltage code
  task automatic t_vout;
    logic [7:0] c [6] = '{8'h14, 8'h17, 8'h18, 8'h9D, 8'h9E, 8'hFF};
    logic [11:0] m [6] = '{12'h2BC, 12'h2DA, 12'h2DF, 12'h578, 12'h58C, 12'hD20};
    for (int i = 0; i < 6; i++)
    begin
      bkrc_host_inst.wr(8'h06, c[i]);
      @(posedge clk) #1;
      chk(mv0, m[i]);
    end
  endtask : t_vout
  ////////////////////
  // main sequence after a 20-cycle reset
  initial
  begin
    repeat (20) @(posedge clk);
    #1 rst = 0;
    t_defaults();
    t_limits();
    t_reg1();
    t_vout();
    conclude();
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    errors++;
    conclude();
  end
endmodule : test_bkrc_top
